// *** src/spread_mod_pkg.sv ***
package spread_mod_pkg;
    // Shift register geometry
    localparam int LFSR_WIDTH = 15;
    localparam logic [14:0] LFSR_SEED = 15'h0001;
    // Feedback taps for x^15 + x^14 + 1 (maximal length)
    localparam int TAP_HIGH = 14;
    localparam int TAP_LOW = 13;
    localparam int CODE_WIDTH = 7;
    localparam int CODE_LSB = 8;
    localparam logic [6:0] CODE_MID = 7'h40;
    // Rate dividers for each strap level
    localparam int DIV_LOW = 16;
    localparam int DIV_FLOAT = 32;
    localparam int DIV_HIGH = 64;
    localparam int DIV_CNT_WIDTH = 6;
    // Strap pin level encoding
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_FLOAT = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    // Toggle detector: edges counted inside one window of output clocks
    localparam int DET_WINDOW = 16;
    localparam int DET_EDGES = 4;
    localparam int DET_CNT_WIDTH = 5;
    // Scale bounds in tenths of set_current
    localparam int SCALE_MIN_TENTHS = 9;
    localparam int SCALE_MAX_TENTHS = 11;
    // Filter shift: pole near one step period
    localparam int FILT_FRAC = 6;
endpackage

// *** src/toggle_detector.sv ***
`timescale 1ns/10ps
`default_nettype none
module toggle_detector
    import spread_mod_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pin sample and result
    input wire logic pinHigh,
    output logic toggling
);
    logic prevPin, next_prevPin;
    logic [DET_CNT_WIDTH-1:0] winCnt, next_winCnt;
    logic [DET_CNT_WIDTH-1:0] edgeCnt, next_edgeCnt;
    logic next_toggling;
    logic [DET_CNT_WIDTH-1:0] edgeSum;

    // Many edges per window means the pin follows an output clock
    always_comb
    begin
        // Count the edge of the window's last cycle before judging
        edgeSum = edgeCnt;
        if (pinHigh != prevPin && edgeCnt != 5'h1f)
            edgeSum = edgeCnt + 5'h01;
        next_prevPin = pinHigh;
        next_winCnt = winCnt + 5'h01;
        next_edgeCnt = edgeSum;
        next_toggling = toggling;
        if (winCnt == DET_CNT_WIDTH'(DET_WINDOW - 1))
        begin
            next_winCnt = '0;
            next_edgeCnt = '0;
            next_toggling = (edgeSum >= DET_CNT_WIDTH'(DET_EDGES));
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            prevPin <= 1'b0;
            winCnt <= '0;
            edgeCnt <= '0;
            toggling <= 1'b0;
        end
        else
        begin
            prevPin <= next_prevPin;
            winCnt <= next_winCnt;
            edgeCnt <= next_edgeCnt;
            toggling <= next_toggling;
        end
    end
endmodule // toggle_detector
`default_nettype wire

// *** src/pseudo_noise_spread_modulator.sv ***
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Pseudo noise comes from a fifteen-bit linear feedback shift register.
// - Sequence is maximal, repeating after 2^15-1 steps times the divider.
// - Seven register bits form a 128-level code, updated once per step.
// - Register advances once every divider cycles of the output clock.
// - Pin low selects divide 16, floating 32, tied high 64.
// - Toggling near output frequency on the pin stops modulation.
// - Code scales control current between 0.9 and 1.1 of set current.
// - Stepped converter output is single-pole lowpassed at the step rate.
// - With spreading off, frequency stays at nominal with no modulation.
module pseudo_noise_spread_modulator
    import spread_mod_pkg::*;
#(
    parameter int LFSR_BITS = LFSR_WIDTH
)
(
    // Clock (divided output clock) and power-up reset
    input wire logic clock,
    input wire logic rst,
    // Spread rate pin, resolved by the analog front end
    input wire logic [1:0] pinLevel,
    input wire logic pinHigh,
    // Converter code and filtered control
    output logic [CODE_WIDTH-1:0] scaleCode,
    output logic [CODE_WIDTH+FILT_FRAC-1:0] filteredCode,
    output logic stepStrobe,
    output logic spreadActive,
    output logic [1:0] rateSelect
);
    // Taps and code bits are laid out for fifteen bits only
    if (LFSR_BITS != LFSR_WIDTH)
    begin : g_width_check
        $error("Only a fifteen-bit register is supported");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin decode
    logic toggling;
    logic [1:0] pinRate;

    toggle_detector u_toggle_detector (
        .clock(clock),
        .rst(rst),
        .pinHigh(pinHigh),
        .toggling(toggling)
    );

    always_comb
    begin
        case (pinLevel)
            PIN_LOW: pinRate = 2'h0;
            PIN_FLOAT: pinRate = 2'h1;
            PIN_HIGH: pinRate = 2'h2;
            default: pinRate = 2'h1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate divider and shift register
    logic [DIV_CNT_WIDTH-1:0] divCnt, next_divCnt;
    logic [LFSR_WIDTH-1:0] lfsr, next_lfsr;
    logic [1:0] next_rateSelect;
    logic next_spreadActive;
    logic [CODE_WIDTH-1:0] next_scaleCode;
    logic [DIV_CNT_WIDTH-1:0] divLast;
    logic stepNow;

    always_comb
    begin
        case (rateSelect)
            2'h0: divLast = DIV_CNT_WIDTH'(DIV_LOW - 1);
            2'h1: divLast = DIV_CNT_WIDTH'(DIV_FLOAT - 1);
            default: divLast = DIV_CNT_WIDTH'(DIV_HIGH - 1);
        endcase
        stepNow = (divCnt >= divLast);
        next_divCnt = stepNow ? '0 : divCnt + 6'h01;
        next_lfsr = lfsr;
        next_rateSelect = rateSelect;
        next_spreadActive = spreadActive;
        next_scaleCode = scaleCode;
        if (stepNow)
        begin
            // Selection changes only here, so a step never runs short
            next_rateSelect = pinRate;
            next_spreadActive = !toggling;
            // Maximal-length feedback keeps a nonzero state nonzero
            next_lfsr = {lfsr[LFSR_WIDTH-2:0], lfsr[TAP_HIGH] ^ lfsr[TAP_LOW]};
            if (next_lfsr == '0)
                next_lfsr = LFSR_SEED;
            next_scaleCode = next_spreadActive
                ? next_lfsr[CODE_LSB+CODE_WIDTH-1:CODE_LSB] : CODE_MID;
        end
        if (toggling)
        begin
            // Detector stops modulation at once, not waiting for a step
            next_spreadActive = 1'b0;
            next_scaleCode = CODE_MID;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            divCnt <= '0;
            lfsr <= LFSR_SEED;
            rateSelect <= 2'h0;
            spreadActive <= 1'b0;
            scaleCode <= CODE_MID;
            stepStrobe <= 1'b0;
        end
        else
        begin
            divCnt <= next_divCnt;
            lfsr <= next_lfsr;
            rateSelect <= next_rateSelect;
            spreadActive <= next_spreadActive;
            scaleCode <= next_scaleCode;
            stepStrobe <= stepNow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Single-pole smoothing; step count is the rate divider
    // Code 0..127 maps to 0.9..1.1 of set current in the converter
    logic [CODE_WIDTH+FILT_FRAC-1:0] next_filteredCode;
    logic [CODE_WIDTH+FILT_FRAC:0] filtSum;
    logic [CODE_WIDTH+FILT_FRAC-1:0] target;
    logic [2:0] filtShift;

    always_comb
    begin
        target = {scaleCode, {FILT_FRAC{1'b0}}};
        case (rateSelect)
            2'h0: filtShift = 3'h4;
            2'h1: filtShift = 3'h5;
            default: filtShift = 3'h6;
        endcase
        if (target >= filteredCode)
        begin
            filtSum = {1'b0, filteredCode} + {1'b0, (target - filteredCode) >> filtShift};
            if (((target - filteredCode) >> filtShift) == '0 && target != filteredCode)
                filtSum = {1'b0, filteredCode} + 14'h0001;
        end
        else
        begin
            filtSum = {1'b0, filteredCode} - {1'b0, (filteredCode - target) >> filtShift};
            if (((filteredCode - target) >> filtShift) == '0)
                filtSum = {1'b0, filteredCode} - 14'h0001;
        end
        next_filteredCode = filtSum[CODE_WIDTH+FILT_FRAC-1:0];
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            filteredCode <= {CODE_MID, {FILT_FRAC{1'b0}}};
        else
            filteredCode <= next_filteredCode;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Register state and stepping
    AST_NO_LOCKUP: assert property (@(posedge clock) disable iff (rst)
        lfsr != '0) else $error("Shift register hit all-zero state");
    AST_SHIFT_ON_STEP: assert property (@(posedge clock) disable iff (rst)
        stepNow |=> lfsr == {$past(lfsr[13:0]), $past(lfsr[14]) ^ $past(lfsr[13])})
        else $error("Shift register did not advance on step");
    AST_HOLD_BETWEEN: assert property (@(posedge clock) disable iff (rst)
        !stepNow |=> $stable(lfsr)) else $error("Shift register moved between steps");
    AST_STROBE_ONE_CYCLE: assert property (@(posedge clock) disable iff (rst)
        stepStrobe |=> !stepStrobe) else $error("Step strobe stood too long");

    // Step spacing per rate
    AST_DIV16: assert property (@(posedge clock) disable iff (rst)
        (stepStrobe && rateSelect == 2'h0) |-> ##16 stepStrobe)
        else $error("Divide-by-16 spacing wrong");
    AST_DIV32: assert property (@(posedge clock) disable iff (rst)
        (stepStrobe && rateSelect == 2'h1) |-> ##32 stepStrobe)
        else $error("Divide-by-32 spacing wrong");
    AST_DIV64: assert property (@(posedge clock) disable iff (rst)
        (stepStrobe && rateSelect == 2'h2) |=> !stepStrobe [*8])
        else $error("Divide-by-64 stepped too soon");
    AST_DIV64_SPACING: assert property (@(posedge clock) disable iff (rst)
        (stepStrobe && rateSelect == 2'h2) |-> ##64 stepStrobe)
        else $error("Divide-by-64 spacing wrong");
    AST_RATE_ON_STEP: assert property (@(posedge clock) disable iff (rst)
        $changed(rateSelect) |-> stepStrobe)
        else $error("Rate changed off a step boundary");
    AST_REENABLE_ON_STEP: assert property (@(posedge clock) disable iff (rst)
        $rose(spreadActive) |-> stepStrobe)
        else $error("Spreading resumed off a step boundary");

    // Code and modulation state
    AST_CODE_BITS: assert property (@(posedge clock) disable iff (rst)
        (stepStrobe && spreadActive) |-> scaleCode == lfsr[14:8])
        else $error("Code does not follow register bits");
    AST_CODE_ON_STEP: assert property (@(posedge clock) disable iff (rst)
        $changed(scaleCode) |-> stepStrobe || $past(toggling))
        else $error("Code changed between steps");
    AST_STOP_ON_TOGGLE: assert property (@(posedge clock) disable iff (rst)
        toggling |=> !spreadActive && scaleCode == CODE_MID)
        else $error("Modulation not stopped");
    AST_NOMINAL_HOLD: assert property (@(posedge clock) disable iff (rst)
        (!spreadActive && !$past(spreadActive)) |-> scaleCode == CODE_MID)
        else $error("Code moved while spreading off");

    // Smoothing filter
    AST_FILT_MOVES: assert property (@(posedge clock) disable iff (rst)
        (filteredCode != target) |=> filteredCode != $past(filteredCode))
        else $error("Filter stalled short of its target");
    AST_FILT_UP: assert property (@(posedge clock) disable iff (rst)
        (filteredCode <= target) |=> filteredCode <= $past(target))
        else $error("Filter overshot upward");
    AST_FILT_DOWN: assert property (@(posedge clock) disable iff (rst)
        (filteredCode >= target) |=> filteredCode >= $past(target))
        else $error("Filter overshot downward");
endmodule // pseudo_noise_spread_modulator
`default_nettype wire

// *** verification/spread_pin_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module spread_pin_model
    import spread_mod_pkg::*;
(
    // Clock and board choice
    input wire logic clock,
    input wire logic [1:0] strap,
    input wire logic feedback,
    // Resolved pin
    output logic [1:0] pinLevel,
    output logic pinHigh
);
    logic fbClock = 1'b0;
    // An active output looped back toggles every output clock
    always_ff @(posedge clock)
    begin
        fbClock <= ~fbClock;
    end
    assign pinHigh = feedback ? fbClock : (strap == PIN_HIGH);
    // A looped-back clock averages to mid supply
    assign pinLevel = feedback ? PIN_FLOAT : strap;
endmodule // spread_pin_model
`default_nettype wire

// *** verification/pseudo_noise_spread_modulator_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module pseudo_noise_spread_modulator_bench;
    import spread_mod_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [1:0] strap = PIN_LOW;
    logic feedback = 1'b0;
    logic [1:0] pinLevel;
    logic pinHigh;
    logic [6:0] scaleCode;
    logic [12:0] filteredCode;
    logic stepStrobe;
    logic spreadActive;
    logic [1:0] rateSelect;
    int numErrors = 0;
    int cmpCount = 0;
    int cycles = 0;
    always #25 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    spread_pin_model u_spread_pin_model (.clock(clock), .strap(strap), .feedback(feedback),
        .pinLevel(pinLevel), .pinHigh(pinHigh));
    pseudo_noise_spread_modulator u_pseudo_noise_spread_modulator (.clock(clock), .rst(rst),
        .pinLevel(pinLevel), .pinHigh(pinHigh), .scaleCode(scaleCode),
        .filteredCode(filteredCode), .stepStrobe(stepStrobe),
        .spreadActive(spreadActive), .rateSelect(rateSelect));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        cmpCount++;
        if (seen !== expected)
        begin
            numErrors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic printVerdict();
        $display("errors %0d compares %0d", numErrors, cmpCount);
        if (numErrors == 0 && cmpCount > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Bounded wait; returns cycles since the call
    task automatic waitStrobe(output int n);
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end while (stepStrobe !== 1'b1 && n < 200);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        check(scaleCode, CODE_MID);
        check(filteredCode, 16'h1000);
        check({spreadActive, stepStrobe, rateSelect}, 0);
    endtask
    // Golden shift register compared at each of the first 100 steps from the seed
    task automatic testSequence();
        logic [14:0] lfsr;
        int n;
        lfsr = LFSR_SEED;
        for (int i = 0; i < 100; i++)
        begin
            waitStrobe(n);
            if (i > 0)
                check(n, DIV_LOW);
            lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
            check(scaleCode, lfsr[14:8]);
            check(spreadActive, 1);
        end
    endtask
    task automatic testRates();
        logic [1:0] lv[4] = '{PIN_FLOAT, PIN_HIGH, 2'h3, PIN_LOW};
        int dv[4] = '{DIV_FLOAT, DIV_HIGH, DIV_FLOAT, DIV_LOW};
        int n;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            #5 strap = lv[i];
            waitStrobe(n);
            waitStrobe(n);
            check(n, dv[i]);
            check(rateSelect, (dv[i] == DIV_LOW) ? 0 : (dv[i] == DIV_FLOAT) ? 1 : 2);
        end
    endtask
    task automatic testFeedback();
        int n;
        @(posedge clock);
        #5 feedback = 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end while (spreadActive !== 1'b0 && n < 40);
        check(spreadActive, 0);
        @(posedge clock);
        #1 check(scaleCode, CODE_MID);
        // Filter must settle on nominal while spreading is off
        repeat (800) @(posedge clock);
        #1 check(filteredCode, 16'h1000);
        check(scaleCode, CODE_MID);
        #4 feedback = 1'b0;
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end while (spreadActive !== 1'b1 && n < 80);
        check(spreadActive, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            numErrors++;
            printVerdict();
        end
    end
    initial
    begin
        repeat (12) @(posedge clock);
        testReset();
        #5 rst = 1'b0;
        testSequence();
        testRates();
        testFeedback();
        printVerdict();
    end
endmodule // pseudo_noise_spread_modulator_bench
`default_nettype wire
